// File: fpe_params.svh
// Constants for the flash program/erase host sequencer.
// Assumes a 10 MHz system clock and a 16-bit parallel flash outside.
`ifndef FPE_PARAMS_SVH
`define FPE_PARAMS_SVH

`define FPE_CLK_PERIOD_NS        100
`define FPE_PROG_MAX_US          50
`define FPE_PROG_MAX_CYC         ((`FPE_PROG_MAX_US * 1000) / `FPE_CLK_PERIOD_NS)
`define FPE_ERASE_MAX_S          3
// Divide first: three seconds in nanoseconds overflows a 32-bit int
`define FPE_ERASE_MAX_CYC        (`FPE_ERASE_MAX_S * (1000000000 / `FPE_CLK_PERIOD_NS))
`define FPE_POLL_HIGH_MIN_NS     150
`define FPE_POLL_HIGH_CYC        \
    ((`FPE_POLL_HIGH_MIN_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS)
`define FPE_CMD_CHIP_ERASE       16'h0010
`define FPE_CMD_MAIN_ERASE       16'h0030
`define FPE_TOGGLE_BIT           6
`define FPE_POLL_BIT             7

`endif

// File: fpe_pkg.sv
// Types for the flash program/erase host sequencer.
// Assumes fpe_params.svh supplies the numeric constants.
package fpe_pkg;

    typedef enum logic [1:0]
    {
        FPE_OP_PROG       = 2'h0,
        FPE_OP_CHIP_ERASE = 2'h1,
        FPE_OP_MAIN_ERASE = 2'h2
    } fpe_op_t;

    typedef struct packed
    {
        fpe_op_t     op;
        logic [15:0] addr;
        logic [15:0] data;
    } fpe_req_t;

    typedef struct packed
    {
        logic        ce_b;
        logic        oe_b;
        logic        we_b;
        logic [15:0] addr;
        logic [15:0] dq_out;
        logic        dq_oe_b;
    } fpe_pins_t;

endpackage

// File: fpe_host.sv
// Host sequencer: writes the final program or erase cycle, then polls
// the toggle status line until it stops changing (for a program, also until the poll bit matches the data) or a timeout expires.
// Assumes the unlock cycles, if any, are issued by the caller beforehand.
`include "fpe_params.svh"

module fpe_host #(
    parameter int PROG_CYC  = `FPE_PROG_MAX_CYC,
    parameter int ERASE_CYC = `FPE_ERASE_MAX_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              req_valid,
    input  wire fpe_pkg::fpe_req_t req,
    output logic                   req_ready,
    output logic                   done,
    output logic                   timeout,
    output fpe_pkg::fpe_pins_t     pins,
    input  wire logic [15:0]       dq_in
);

    localparam int HIGH_CYC = `FPE_POLL_HIGH_CYC;

    typedef enum logic [5:0]
    {
        S_IDLE  = 6'h01,
        S_WRITE = 6'h02,
        S_HIGH  = 6'h04,
        S_READ  = 6'h08,
        S_CHECK = 6'h10,
        S_DONE  = 6'h20
    } fpe_state_t;

    // ========================================================
    // State
    // ========================================================
    fpe_state_t         state_r, state_nxt;
    fpe_pkg::fpe_req_t  req_r, req_nxt;
    fpe_pkg::fpe_pins_t pins_r, pins_nxt;
    logic [31:0]        tmo_r, tmo_nxt;
    logic [3:0]         cnt_r, cnt_nxt;
    logic               prev_r, prev_nxt;
    logic               have_r, have_nxt;
    logic               done_r, done_nxt;
    logic               tout_r, tout_nxt;
    logic               rdy_r, rdy_nxt;

    always_comb
    begin
        state_nxt = state_r;
        req_nxt   = req_r;
        pins_nxt  = pins_r;
        tmo_nxt   = tmo_r;
        cnt_nxt   = cnt_r;
        prev_nxt  = prev_r;
        have_nxt  = have_r;
        done_nxt  = 1'b0;
        tout_nxt  = 1'b0;
        rdy_nxt   = 1'b0;
        unique case (state_r)
            S_IDLE:
            begin
                rdy_nxt = 1'b1;
                if (req_valid && rdy_r)
                begin
                    rdy_nxt = 1'b0;
                    req_nxt = req;
                    pins_nxt.addr = req.addr;
                    pins_nxt.dq_out = (req.op == fpe_pkg::FPE_OP_CHIP_ERASE) ?
                                      `FPE_CMD_CHIP_ERASE :
                                      (req.op == fpe_pkg::FPE_OP_MAIN_ERASE) ?
                                      `FPE_CMD_MAIN_ERASE : req.data;
                    pins_nxt.dq_oe_b = 1'b0;
                    pins_nxt.ce_b    = 1'b0;
                    pins_nxt.we_b    = 1'b0;
                    pins_nxt.oe_b    = 1'b1;
                    cnt_nxt   = 4'h0;
                    have_nxt  = 1'b0;
                    tmo_nxt   = (req.op == fpe_pkg::FPE_OP_PROG) ?
                                PROG_CYC[31:0] : ERASE_CYC[31:0];
                    state_nxt = S_WRITE;
                end
            end
            S_WRITE:
            begin
                // Write pulse one cycle (100 ns) meets the 50 ns minimum
                pins_nxt.we_b    = 1'b1;
                pins_nxt.ce_b    = 1'b1;
                pins_nxt.dq_oe_b = 1'b1;
                state_nxt = S_HIGH;
            end
            S_HIGH:
            begin
                pins_nxt.oe_b = 1'b1;
                pins_nxt.ce_b = 1'b1;
                cnt_nxt = cnt_r + 4'h1;
                if (tmo_r != 32'h0)
                    tmo_nxt = tmo_r - 32'h1;
                if (cnt_r + 4'h1 >= HIGH_CYC[3:0])
                begin
                    pins_nxt.oe_b = 1'b0;
                    pins_nxt.ce_b = 1'b0;
                    state_nxt = S_READ;
                end
            end
            S_READ:
            begin
                // Access time is under one cycle; sample one cycle later
                if (tmo_r != 32'h0)
                    tmo_nxt = tmo_r - 32'h1;
                state_nxt = S_CHECK;
            end
            S_CHECK:
            begin
                pins_nxt.oe_b = 1'b1;
                pins_nxt.ce_b = 1'b1;
                cnt_nxt  = 4'h0;
                prev_nxt = dq_in[`FPE_TOGGLE_BIT];
                have_nxt = 1'b1;
                if (have_r && (dq_in[`FPE_TOGGLE_BIT] == prev_r) &&
                    ((req_r.op != fpe_pkg::FPE_OP_PROG) ||
                     (dq_in[`FPE_POLL_BIT] == req_r.data[`FPE_POLL_BIT])))
                begin
                    done_nxt  = 1'b1;
                    state_nxt = S_DONE;
                end
                else if (tmo_r == 32'h0)
                begin
                    tout_nxt  = 1'b1;
                    state_nxt = S_DONE;
                end
                else
                begin
                    tmo_nxt   = tmo_r - 32'h1;
                    state_nxt = S_HIGH;
                end
            end
            S_DONE:
            begin
                rdy_nxt   = 1'b1;
                state_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            state_r <= S_IDLE;
            req_r   <= '0;
            pins_r  <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, addr: 16'h0000,
                         dq_out: 16'h0000, dq_oe_b: 1'b1};
            tmo_r   <= 32'h0;
            cnt_r   <= 4'h0;
            prev_r  <= 1'b0;
            have_r  <= 1'b0;
            done_r  <= 1'b0;
            tout_r  <= 1'b0;
            rdy_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            req_r   <= req_nxt;
            pins_r  <= pins_nxt;
            tmo_r   <= tmo_nxt;
            cnt_r   <= cnt_nxt;
            prev_r  <= prev_nxt;
            have_r  <= have_nxt;
            done_r  <= done_nxt;
            tout_r  <= tout_nxt;
            rdy_r   <= rdy_nxt;
        end
    end

    assign pins      = pins_r;
    assign done      = done_r;
    assign timeout   = tout_r;
    assign req_ready = rdy_r;

    // ========================================================
    // Checks
    // ========================================================
    // Cycles since the request was taken; only the bound checks read it
    logic [31:0]        age_r, age_nxt;
    logic [31:0]        tmo_limit;

    always_comb
    begin
        age_nxt   = (state_r == S_IDLE) ? 32'h0 : age_r + 32'h1;
        tmo_limit = (req_r.op == fpe_pkg::FPE_OP_PROG) ? PROG_CYC[31:0] : ERASE_CYC[31:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            age_r <= 32'h0;
        else
            age_r <= age_nxt;
    end

    sequence s_write_pulse;
        !pins_r.we_b && !pins_r.ce_b;
    endsequence

    a_erase_oe_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_write_pulse |-> pins_r.oe_b)
        else $error("oe low during write pulse");

    a_chip_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_write_pulse and req_r.op == fpe_pkg::FPE_OP_CHIP_ERASE)
        |-> pins_r.dq_out == 16'h0010)
        else $error("chip erase code wrong");

    a_main_code: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (s_write_pulse and req_r.op == fpe_pkg::FPE_OP_MAIN_ERASE)
        |-> pins_r.dq_out == 16'h0030)
        else $error("main erase code wrong");

    a_poll_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(pins_r.oe_b) && state_r == S_HIGH |-> pins_r.oe_b[*2])
        else $error("poll high pulse too short");

    a_addr_stable: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_r != S_IDLE && state_nxt != S_IDLE |=> $stable(pins_r.addr))
        else $error("poll address changed");

    a_prog_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tout_r && req_r.op == fpe_pkg::FPE_OP_PROG |-> age_r >= PROG_CYC[31:0])
        else $error("program timeout declared early");

    a_erase_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tout_r && req_r.op != fpe_pkg::FPE_OP_PROG |-> age_r >= ERASE_CYC[31:0])
        else $error("erase timeout declared early");

    a_poll_ends: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_r != S_IDLE |-> age_r <= tmo_limit + 32'h8)
        else $error("polling outlived its bound");

    a_poll_bit_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_r == S_CHECK && req_r.op == fpe_pkg::FPE_OP_PROG &&
        dq_in[`FPE_POLL_BIT] != req_r.data[`FPE_POLL_BIT] |=> !done_r)
        else $error("done while poll bit complemented");

    a_stable_done: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_r == S_CHECK && have_r && dq_in[`FPE_TOGGLE_BIT] == prev_r &&
        req_r.op != fpe_pkg::FPE_OP_PROG |=> done_r)
        else $error("stable toggle not reported done");

    a_toggle_retry: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_r == S_CHECK && have_r && dq_in[`FPE_TOGGLE_BIT] != prev_r &&
        tmo_r != 32'h0 |=> state_r == S_HIGH && !done_r)
        else $error("toggling device treated as done");

endmodule // fpe_host

// File: fpe_flash_model.sv
// Flash model: takes the final command cycle, stays busy for a chosen
// count answering status reads, then returns the written word. Assumes pins change on clk_sys.
module fpe_flash_model
(
    input  wire logic               clk_sys,
    input  wire fpe_pkg::fpe_pins_t pins,
    input  wire logic [15:0]        busy_cyc,
    output logic [15:0]             dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] busy_cnt = 16'h0000;
    logic [15:0] wdata    = 16'h0000;
    logic [15:0] last     = 16'h0000;
    logic        tog      = 1'b0;
    logic        rd_prev  = 1'b0;
    logic        rd;
    assign rd = !pins.ce_b && !pins.oe_b;
    // ==========
    // Internal timer
    // busy time
    always @(posedge clk_sys)
    begin
        if (!pins.ce_b && !pins.we_b)
        begin
            wdata <= pins.dq_out;
            busy_cnt <= busy_cyc;
        end
        else if (busy_cnt != 16'h0000)
            busy_cnt <= busy_cnt - 16'h0001;
        if (rd && !rd_prev && busy_cnt != 16'h0000)
            tog <= ~tog;
        rd_prev <= rd;
        if (rd)
            last <= dq_in;
    end
    // ==========
    // Read data
    // status answer
    always_comb
    begin
        // Released lines must not keep the last value
        if (!rd)
            dq_in = ~last;
        else if (busy_cnt != 16'h0000)
            dq_in = {8'h00, ~wdata[7], tog, 6'h00};
        else
            dq_in = wdata;
    end
endmodule // fpe_flash_model

// File: fpe_host_bench.sv
// Bench for fpe_host with a behavioural flash on its pins.
// Assumes short timeout counts; every figure is in 100 ns cycles.
module fpe_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PCYC = 40;
    localparam int ECYC = 100;
    logic               clk_sys;
    logic               rst_b;
    logic               req_valid;
    logic               req_ready;
    logic               done;
    logic               timeout;
    fpe_pkg::fpe_req_t  req;
    fpe_pkg::fpe_pins_t pins;
    logic [15:0]        dq_in;
    logic [15:0]        busy_cyc;
    logic [15:0]        wr_data    = 16'h0000;
    logic [15:0]        cur_addr;
    int                 num_errors = 0;
    int                 checked    = 0;
    int                 hi_cnt     = 0;
    fpe_host #(.PROG_CYC(PCYC), .ERASE_CYC(ECYC)) i_fpe_host (.clk_sys(clk_sys),
        .rst_b(rst_b), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .done(done), .timeout(timeout), .pins(pins), .dq_in(dq_in));
    fpe_flash_model i_fpe_flash_model (.clk_sys(clk_sys), .pins(pins),
        .busy_cyc(busy_cyc), .dq_in(dq_in));
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ==========
    // Checking
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Pins are registered, so sampling at the edge sees settled values
    always @(posedge clk_sys)
    begin
        if (rst_b && !pins.ce_b && !pins.we_b)
        begin
            wr_data <= pins.dq_out;
            check({15'h0, pins.oe_b}, 16'h0001);
            check({15'h0, pins.dq_oe_b}, 16'h0000);
        end
        if (rst_b && !pins.ce_b && !pins.oe_b)
        begin
            check(pins.addr, cur_addr);
            check({15'h0, pins.dq_oe_b}, 16'h0001);
        end
        if (pins.oe_b)
            hi_cnt <= hi_cnt + 1;
        else
        begin
            if (hi_cnt != 0)
                check({15'h0, hi_cnt >= 2}, 16'h0001);
            hi_cnt <= 0;
        end
    end
    // ==========
    // Scenario
    task automatic run_op(input fpe_pkg::fpe_op_t op, input logic [15:0] a, d, bsy,
                          input logic exp_done, input logic [15:0] exp_wr);
        int n;
        int bound;
        bound = (op == fpe_pkg::FPE_OP_PROG) ? PCYC : ECYC;
        busy_cyc = bsy;
        cur_addr = a;
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            #10;
            n++;
        end
        if (req_ready !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: request never accepted", $time);
            req_valid = 1'b0;
            return;
        end
        @(posedge clk_sys);
        #10;
        req_valid = 1'b0;
        check({15'h0, req_ready}, 16'h0000);
        n = 0;
        while (done !== 1'b1 && timeout !== 1'b1 && n < 1000)
        begin
            @(posedge clk_sys);
            #10;
            n++;
        end
        if (done !== 1'b1 && timeout !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: no done or timeout", $time);
            return;
        end
        check({15'h0, done}, {15'h0, exp_done});
        check({15'h0, timeout}, {15'h0, ~exp_done});
        check(wr_data, exp_wr);
        // Done may not come before the flash has stopped being busy
        if (exp_done)
            check({15'h0, n >= bsy}, 16'h0001);
        else
        begin
            check({15'h0, n >= bound}, 16'h0001);
            check({15'h0, n <= bound + 8}, 16'h0001);
        end
    endtask
    initial
    begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        busy_cyc = 16'h0001;
        cur_addr = 16'h0000;
        repeat (8) @(posedge clk_sys);
        #10;
        check({13'h0, pins.ce_b, pins.oe_b, pins.we_b}, 16'h0007);
        rst_b = 1'b1;
        run_op(fpe_pkg::FPE_OP_PROG, 16'h1234, 16'h9a5c, 16'h0014, 1'b1, 16'h9a5c);
        run_op(fpe_pkg::FPE_OP_PROG, 16'h1234, 16'h2b87, 16'h0014, 1'b1, 16'h2b87);
        run_op(fpe_pkg::FPE_OP_PROG, 16'hfffe, 16'h5555, 16'h00c8, 1'b0, 16'h5555);
        run_op(fpe_pkg::FPE_OP_CHIP_ERASE, 16'h0000, 16'h0000, 16'h001e, 1'b1, 16'h0010);
        run_op(fpe_pkg::FPE_OP_MAIN_ERASE, 16'h8000, 16'h0000, 16'h001e, 1'b1, 16'h0030);
        run_op(fpe_pkg::FPE_OP_MAIN_ERASE, 16'h8000, 16'h0000, 16'h012c, 1'b0, 16'h0030);
        run_op(fpe_pkg::FPE_OP_CHIP_ERASE, 16'h0abc, 16'h0000, 16'h0032, 1'b1, 16'h0010);
        tally_and_finish();
    end
endmodule // fpe_host_bench
